// file: design/pipr_params.svh
/*
 Constants of the peripheral input pin router: register map, field
 positions, reset defaults and the port groups that this variant has.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef PIPR_PARAMS_SVH
`define PIPR_PARAMS_SVH

`define PIPR_NUM_INPUTS 4
`define PIPR_NUM_GROUPS 6
`define PIPR_PIN_W 48
`define PIPR_ADDR_W 8
`define PIPR_DATA_W 8
`define PIPR_SEL_W 6

// Register offsets: one aligned word per peripheral input
`define PIPR_OFS_SEL0 8'h00
`define PIPR_OFS_SEL1 8'h04
`define PIPR_OFS_SEL2 8'h08
`define PIPR_OFS_SEL3 8'h0c
`define PIPR_ADDR_HI_MASK 8'hf0
`define PIPR_ADDR_LO_MASK 8'h03
`define PIPR_IDX_MSB 3
`define PIPR_IDX_LSB 2

// Field layout of a selection register
`define PIPR_GRP_MSB 5
`define PIPR_GRP_LSB 3
`define PIPR_PIN_MSB 2
`define PIPR_PIN_LSB 0
`define PIPR_IMPL_MASK 8'h3f
`define PIPR_GRP_PINS 8

// Port group codes
`define PIPR_GRP_A 3'h0
`define PIPR_GRP_B 3'h1
`define PIPR_GRP_C 3'h2
`define PIPR_GRP_D 3'h3
`define PIPR_GRP_E 3'h4
`define PIPR_GRP_F 3'h5

// Groups present on this variant, bit n for group code n
`define PIPR_GRP_PRESENT 6'h3f

// Default locations loaded at power-on or brown-out reset
`define PIPR_DFLT_SEL0 6'h00
`define PIPR_DFLT_SEL1 6'h09
`define PIPR_DFLT_SEL2 6'h12
`define PIPR_DFLT_SEL3 6'h0b

`endif

// file: design/pipr_pkg.sv
/*
 Types of the peripheral input pin router.
 Assumes pipr_params.svh on the include path.
*/
`include "pipr_params.svh"

package pipr_pkg;

    typedef logic [`PIPR_SEL_W-1:0] pipr_sel_t;

    typedef struct packed {
        pipr_sel_t [`PIPR_NUM_INPUTS-1:0] sel;
        logic [`PIPR_DATA_W-1:0] rdata;
        logic [`PIPR_NUM_INPUTS-1:0] periph;
    } pipr_state_t;

    typedef struct packed {
        logic [`PIPR_PIN_W-1:0] meta;
        logic [`PIPR_PIN_W-1:0] sync;
    } pipr_sync_state_t;

endpackage

// file: design/pipr_pin_sync.sv
/*
 Two-flop synchroniser for all port pins.
 Assumes pins arrive asynchronously to mclk_in.
*/
`timescale 1ns/1ns
`include "pipr_params.svh"

module pipr_pin_sync (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [`PIPR_PIN_W-1:0] pins_in,
    output logic [`PIPR_PIN_W-1:0] pins_sync_out
);

    pipr_pkg::pipr_sync_state_t state_r;
    pipr_pkg::pipr_sync_state_t state_nxt;

    // The first stage feeds only the second
    always_comb begin
        state_nxt = state_r;
        state_nxt.meta = pins_in;
        state_nxt.sync = state_r.meta;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pins_sync_out = state_r.sync;

endmodule

// file: design/pipr_router.sv
/*
 Peripheral input pin router: one selection register per peripheral
 input picks a port group and pin, and that pin drives the input.
 Assumes a register master with one-cycle strobes, pins from outside
 the clock domain, rst_n_in as power-on/brown-out reset and
 other_rst_in as a synchronous pulse for every other reset source.
*/
`timescale 1ns/1ns
`include "pipr_params.svh"

// Behaviour
// - Bits 7-6 of each selection register ignore writes and read zero.
// - Bits 5-3 choose port group A to F by codes 000 to 101.
// - Bits 2-0 choose pin 0 to 7; that pin feeds the peripheral input.
// - Power-on or brown-out reset loads each selection register with its own default pin location; other_rst_in keeps it.
// - Codes of absent port groups are reserved and route a constant zero.
module pipr_router (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic other_rst_in,
    input wire logic [`PIPR_ADDR_W-1:0] addr_in,
    input wire logic [`PIPR_DATA_W-1:0] wdata_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [`PIPR_PIN_W-1:0] port_pins_in,
    output logic [`PIPR_DATA_W-1:0] rdata_out,
    output logic [`PIPR_NUM_INPUTS-1:0] periph_in_out
);

    pipr_pkg::pipr_state_t state_r;
    pipr_pkg::pipr_state_t state_nxt;
    logic [`PIPR_PIN_W-1:0] pins_sync;
    logic boot_r;

    localparam pipr_pkg::pipr_sel_t DFLT [`PIPR_NUM_INPUTS] = '{
        `PIPR_DFLT_SEL0, `PIPR_DFLT_SEL1, `PIPR_DFLT_SEL2, `PIPR_DFLT_SEL3
    };

    // Widened so that codes 110 and 111 index a defined zero
    localparam logic [7:0] GRP_PRESENT = {2'h0, `PIPR_GRP_PRESENT};

    pipr_pin_sync u_sync (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .pins_in(port_pins_in),
        .pins_sync_out(pins_sync)
    );

    // Decodes a register address; valid only on an aligned mapped word
    function automatic logic addr_hit(input logic [`PIPR_ADDR_W-1:0] a);
        addr_hit = ((a & `PIPR_ADDR_HI_MASK) == 8'h00) && ((a & `PIPR_ADDR_LO_MASK) == 8'h00);
    endfunction

    function automatic logic [1:0] addr_idx(input logic [`PIPR_ADDR_W-1:0] a);
        addr_idx = a[`PIPR_IDX_MSB:`PIPR_IDX_LSB];
    endfunction

    function automatic logic [2:0] grp_of(input pipr_pkg::pipr_sel_t s);
        grp_of = s[`PIPR_GRP_MSB:`PIPR_GRP_LSB];
    endfunction

    function automatic logic [2:0] pin_of(input pipr_pkg::pipr_sel_t s);
        pin_of = s[`PIPR_PIN_MSB:`PIPR_PIN_LSB];
    endfunction

    function automatic logic grp_valid(input logic [2:0] g);
        grp_valid = (g <= `PIPR_GRP_F) && GRP_PRESENT[g];
    endfunction

    // Picks the chosen pin; a reserved group gives zero rather than a stale pin
    function automatic logic route(input pipr_pkg::pipr_sel_t s,
                                   input logic [`PIPR_PIN_W-1:0] p);
        logic [2:0] g;
        logic [2:0] n;
        g = grp_of(s);
        n = pin_of(s);
        if (grp_valid(g)) begin
            route = p[{g, n}];
        end else begin
            route = 1'b0;
        end
    endfunction

    always_comb begin
        state_nxt = state_r;
        state_nxt.rdata = 8'h00;
        if (wr_en_in && addr_hit(addr_in)) begin
            // Upper two bits dropped here
            state_nxt.sel[addr_idx(addr_in)] = wdata_in[`PIPR_SEL_W-1:0];
        end
        if (rd_en_in && addr_hit(addr_in)) begin
            state_nxt.rdata = {2'h0, state_r.sel[addr_idx(addr_in)]};
        end
        for (int i = 0; i < `PIPR_NUM_INPUTS; i++) begin
            state_nxt.periph[i] = route(state_r.sel[i], pins_sync);
        end
        if (other_rst_in) begin
            // Selections kept across non-power-on resets
            state_nxt.sel = state_r.sel;
            state_nxt.periph = '0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r.sel[0] <= `PIPR_DFLT_SEL0;
            state_r.sel[1] <= `PIPR_DFLT_SEL1;
            state_r.sel[2] <= `PIPR_DFLT_SEL2;
            state_r.sel[3] <= `PIPR_DFLT_SEL3;
            state_r.rdata <= 8'h00;
            state_r.periph <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Helper for checks: high in the first cycle after reset release
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            boot_r <= 1'b1;
        end else begin
            boot_r <= 1'b0;
        end
    end

    assign rdata_out = state_r.rdata;
    assign periph_in_out = state_r.periph;

    AST_RD_TOP_ZERO: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        rd_en_in |=> (rdata_out[`PIPR_DATA_W-1:`PIPR_SEL_W] == 2'h0)
    ) else $error("Unimplemented bits read nonzero");

    AST_WR_RD_BACK: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_en_in && addr_hit(addr_in) && !other_rst_in) ##1 (rd_en_in && !wr_en_in
            && (addr_in == $past(addr_in)))
        |=> (rdata_out == ($past(wdata_in, 2) & `PIPR_IMPL_MASK))
    ) else $error("Read back differs from written selection");

    AST_UNMAPPED_RD: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (rd_en_in && !addr_hit(addr_in)) |=> (rdata_out == 8'h00)
    ) else $error("Unmapped read not zero");

    AST_DEFAULTS: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        boot_r |-> (state_r.sel[0] == `PIPR_DFLT_SEL0) && (state_r.sel[1] == `PIPR_DFLT_SEL1)
            && (state_r.sel[2] == `PIPR_DFLT_SEL2) && (state_r.sel[3] == `PIPR_DFLT_SEL3)
    ) else $error("Selection not at default after reset");

    AST_OTHER_RST_KEEP: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        other_rst_in |=> $stable(state_r.sel)
    ) else $error("Other reset changed a selection");

    AST_RD_IDLE_ZERO: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        !rd_en_in |=> (rdata_out == 8'h00)
    ) else $error("Read data stood without a read");

    AST_RD_DATA: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (rd_en_in && addr_hit(addr_in))
        |=> (rdata_out == {2'h0, $past(state_r.sel[addr_idx(addr_in)])})
    ) else $error("Read data differ from the selection");

    AST_WR_UPDATE: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_en_in && addr_hit(addr_in) && !other_rst_in)
        |=> (state_r.sel[$past(addr_idx(addr_in))] == $past(wdata_in[`PIPR_SEL_W-1:0]))
    ) else $error("Write did not reach its selection");

    AST_WR_UNMAPPED_KEEP: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_en_in && !addr_hit(addr_in)) |=> $stable(state_r.sel)
    ) else $error("Unmapped write changed a selection");

    AST_NO_WR_KEEP: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        !wr_en_in |=> $stable(state_r.sel)
    ) else $error("Selection changed without a write");

    AST_OTHER_RST_CLEAR: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        other_rst_in |=> (periph_in_out == '0)
    ) else $error("Other reset left a routed input high");

    AST_BOOT_IDLE: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        boot_r |-> (periph_in_out == '0) && (rdata_out == 8'h00) && (pins_sync == '0)
    ) else $error("Outputs not idle after reset");

    // Two edges of latency is the price of a metastability-safe pin path
    AST_SYNC_DELAY: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (!boot_r && !$past(boot_r)) |-> (pins_sync == $past(port_pins_in, 2))
    ) else $error("Pin synchroniser latency wrong");

    generate
        for (genvar gi = 0; gi < `PIPR_NUM_INPUTS; gi++) begin : g_chk
            AST_ROUTE_PIN: assert property (
                @(posedge mclk_in) disable iff (!rst_n_in)
                (!other_rst_in && grp_valid(grp_of(state_r.sel[gi])))
                |=> (periph_in_out[gi] == $past(pins_sync[{grp_of(state_r.sel[gi]),
                    pin_of(state_r.sel[gi])}]))
            ) else $error("Routed input differs from selected pin");

            AST_GROUP_A_PIN0: assert property (
                @(posedge mclk_in) disable iff (!rst_n_in)
                (!other_rst_in && state_r.sel[gi] == 6'h00) |=> (periph_in_out[gi]
                    == $past(pins_sync[0]))
            ) else $error("Group A pin 0 not routed");

            AST_RESERVED_ZERO: assert property (
                @(posedge mclk_in) disable iff (!rst_n_in)
                !grp_valid(grp_of(state_r.sel[gi])) |=> !periph_in_out[gi]
            ) else $error("Reserved group drove a peripheral input");

            AST_DFLT_EACH: assert property (
                @(posedge mclk_in) disable iff (!rst_n_in)
                boot_r |-> (state_r.sel[gi] == DFLT[gi])
            ) else $error("Selection not at its own default");

            AST_WR_OTHER_KEEP: assert property (
                @(posedge mclk_in) disable iff (!rst_n_in)
                (wr_en_in && (addr_idx(addr_in) != 2'(gi))) |=> $stable(state_r.sel[gi])
            ) else $error("Write changed another selection");

            AST_GROUP_MAP: assert property (
                @(posedge mclk_in) disable iff (!rst_n_in)
                (!other_rst_in && grp_valid(grp_of(state_r.sel[gi])))
                |=> (periph_in_out[gi] == $past(pins_sync[grp_of(state_r.sel[gi])
                    * `PIPR_GRP_PINS + pin_of(state_r.sel[gi])]))
            ) else $error("Group code maps to the wrong pin");
        end
    endgenerate

endmodule

// file: verification/pipr_pin_model.sv
/*
 Far-side model: the port pins feeding the router, moved to the level
 that the bench asks for shortly after each clock edge.
 Assumes the bench drives level_in; real pins are asynchronous.
*/
`timescale 1ns/1ns
`include "pipr_params.svh"
module pipr_pin_model (
    input wire logic mclk_in,
    input wire logic [`PIPR_PIN_W-1:0] level_in,
    output logic [`PIPR_PIN_W-1:0] pins_out
);
    initial pins_out = '0;
    // Offset from the edge so the pins do not look clock-aligned
    always @(posedge mclk_in) begin
        pins_out <= #2 level_in;
    end
endmodule

// file: verification/test_pipr_router.sv
/*
 Self-checking bench of the peripheral input pin router.
 Assumes the design files are compiled first; read results are queued.
*/
`timescale 1ns/1ns
`include "pipr_params.svh"
module test_pipr_router;
    logic mclk_in = 0, rst_n_in = 0, other_rst_in = 0, wr_en_in = 0, rd_en_in = 0, rd_d = 0;
    logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
    logic [`PIPR_PIN_W-1:0] level = '0, pins;
    logic [3:0] periph_in_out;
    logic [7:0] exp_q[$];
    logic [7:0] exp_p[$];
    logic look_p = 1'b0;
    logic [1:0] look_k = 2'h0;
    logic [5:0] dflt [4] = '{`PIPR_DFLT_SEL0, `PIPR_DFLT_SEL1, `PIPR_DFLT_SEL2, `PIPR_DFLT_SEL3};
    logic [5:0] cur [4];
    logic [31:0] seed = 32'hfbf091fc;
    int miscompares = 0, checks_done = 0;
    always #5 mclk_in = ~mclk_in;
    pipr_pin_model pipr_pin_model_i (.mclk_in(mclk_in), .level_in(level), .pins_out(pins));
    pipr_router pipr_router_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .other_rst_in(other_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .port_pins_in(pins),
        .rdata_out(rdata_out), .periph_in_out(periph_in_out));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge mclk_in) rd_d <= rd_en_in;
    always @(negedge mclk_in) begin
        if (rd_d) check(rdata_out, exp_q.pop_front());
        if (look_p) check(8'(periph_in_out[look_k]), exp_p.pop_front());
    end
    // Reads take the expected value in d
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        wr_en_in <= w;
        rd_en_in <= ~w;
        addr_in <= a;
        wdata_in <= d;
        if (!w) exp_q.push_back(d);
        @(posedge mclk_in);
    endtask
    task automatic idle(input int n);
        wr_en_in <= 1'b0;
        rd_en_in <= 1'b0;
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic por();
        rst_n_in <= 1'b0;
        repeat (12) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(posedge mclk_in);
        for (int i = 0; i < 4; i++) begin
            cur[i] = dflt[i];
            bus(1'b0, 8'(i * 4), {2'b00, dflt[i]});
        end
    endtask
    initial begin
        #100000;
        miscompares++;
        results();
    end
    initial begin
        logic [31:0] v;
        logic [1:0] k;
        logic [63:0] lv;
        logic [7:0] e;
        @(posedge mclk_in);
        por();
        bus(1'b1, 8'h04, 8'hff);
        bus(1'b0, 8'h04, 8'h3f);
        bus(1'b1, 8'h10, 8'h15);
        bus(1'b0, 8'h10, 8'h00);
        bus(1'b0, 8'h05, 8'h00);
        cur[1] = 6'h3f;
        // Every group and pin code, reserved groups included
        for (int i = 0; i < 64; i++) begin
            v = rnd();
            k = v[1:0];
            cur[k] = i[5:0];
            bus(1'b1, {4'h0, k, 2'b00}, {v[3:2], i[5:0]});
            lv = {rnd(), rnd()};
            level <= lv[`PIPR_PIN_W-1:0];
            idle(5);
            bus(1'b0, {4'h0, k, 2'h0}, {2'h0, i[5:0]});
            idle(1);
            // Pins have long passed the synchroniser; expectation from the pin map
            e = (i[5:3] < `PIPR_NUM_GROUPS) ? 8'(lv[i[5:3] * 8 + i[2:0]]) : 8'h00;
            exp_p.push_back(e);
            look_k <= k;
            look_p <= 1'b1;
            @(posedge mclk_in);
            look_p <= 1'b0;
        end
        // A write beside the other reset must be dropped
        other_rst_in <= 1'b1;
        bus(1'b1, 8'h00, {2'h0, ~cur[0]});
        other_rst_in <= 1'b0;
        for (int i = 0; i < 4; i++) bus(1'b0, 8'(i * 4), {2'b00, cur[i]});
        bus(1'b1, 8'h00, 8'h2a);
        idle(1);
        por();
        idle(3);
        results();
    end
endmodule
